// File: dtc_ctrl.sv
// Purpose: Control registers and clock/run steering for two 8-bit timers
// Assumes: Slow clock and pin inputs are asynchronous levels
// Notes:   Counting datapath is outside; this block drives its controls
//
// Overview of operation
// - Each unit has a control, a period and a width register.
// - Control: preset bit7, clock select 6:4, start bit3, mode 2:0.
// - Normal clock codes pick prescaled high clock, low clock or pin.
// - In slow operation only codes 000, 100, 110 (warm-up only) and 111 give ticks.
// - Mode codes pick 8-bit, 16-bit, warm-up, PWM or pulse modes.
// - 16-bit uses lower clock select, upper start and preset bits.
// - A write starting the timer accepts new mode, clock, preset.
// - Upper stage in 16-bit mode counts on lower overflow.
`timescale 1ns/1ps
module dtc_ctrl
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Asynchronous sources
  input  wire logic       low_freq_clock,
  input  wire logic       lower_pin,
  input  wire logic       upper_pin,
  // Counter datapath side
  input  wire logic       lower_overflow,
  output logic            lower_tick,
  output logic            upper_tick,
  output logic            lower_run,
  output logic            upper_run,
  output logic            lower_ff_preset,
  output logic            upper_ff_preset,
  output logic      [2:0] lower_mode,
  output logic      [2:0] upper_mode,
  output logic            cascade
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] ctrl [2];              // 0 lower, 1 upper
  logic [7:0] period [2];
  logic [7:0] width [2];
  logic [1:0] cfg;
  logic [DTC_PRESCALE_W-1:0] prescale;
  logic [2:0] low_div;
  logic [1:0] lf_sync, lp_sync, up_sync;
  logic       lf_prev, lp_prev, up_prev;
  logic       lf_edge, lp_edge, up_edge;
  logic       lower_cfg_run;
  logic       cascade_sel;
  logic [7:0] next_rdata;
  logic [1:0] src_tick;

  // Register writes; control fields freeze while running unless the write clears start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i]   <= DTC_CTRL_RESET;
        period[i] <= DTC_DATA_RESET;
        width[i]  <= DTC_DATA_RESET;
      end
      cfg <= 2'h0;
    end else if (wr) begin
      for (int i = 0; i < 2; i++) begin
        if (addr == DTC_LOWER_CTRL_ADDR + 8'(i)) begin
          if (!ctrl[i][DTC_RUN_BIT] || !wdata[DTC_RUN_BIT])
            ctrl[i] <= wdata;
          else
            ctrl[i][DTC_RUN_BIT] <= 1'b1;
        end
        if (addr == DTC_LOWER_PER_ADDR + 8'(i))
          period[i] <= wdata;
        if (addr == DTC_LOWER_WID_ADDR + 8'(i))
          width[i] <= wdata;
      end
      if (addr == DTC_CFG_ADDR)
        cfg <= wdata[1:0];
    end
  end

  // Free running prescaler; edges of bit k give high_freq/2^(k+1)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prescale <= '0;
    else     prescale <= prescale + 1'b1;
  end

  // Two-stage synchronisers for the outside levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lf_sync <= 2'b00;
      lp_sync <= 2'b00;
      up_sync <= 2'b00;
      lf_prev <= 1'b0;
      lp_prev <= 1'b0;
      up_prev <= 1'b0;
    end else begin
      lf_sync <= {lf_sync[0], low_freq_clock};
      lp_sync <= {lp_sync[0], lower_pin};
      up_sync <= {up_sync[0], upper_pin};
      lf_prev <= lf_sync[1];
      lp_prev <= lp_sync[1];
      up_prev <= up_sync[1];
    end
  end

  assign lf_edge = lf_sync[1] & ~lf_prev;
  assign lp_edge = lp_sync[1] & ~lp_prev;
  assign up_edge = up_sync[1] & ~up_prev;

  // Low clock divided by 8 for code 000 with the divider source or slow operation set
  always_ff @(posedge clk or posedge rst) begin
    if (rst)          low_div <= 3'h0;
    else if (lf_edge) low_div <= low_div + 1'b1;
  end

  // Per-unit source tick; slow operation drops high-clock taps
  for (genvar u = 0; u < 2; u++) begin : g_src
    logic [2:0] ck;
    logic       pin_edge;
    assign ck = ctrl[u][DTC_CK_MSB:DTC_CK_LSB];
    assign pin_edge = (u == 0) ? lp_edge : up_edge;
    always_comb begin
      src_tick[u] = 1'b0;
      case (ck)
        DTC_CK_DIV11: src_tick[u] = (cfg[DTC_CFG_DIV_BIT] ||
                                     cfg[DTC_CFG_SLOW_BIT]) ?
                                    (lf_edge && low_div == 3'h7) :
                                    (prescale[10:0] == 11'h7FF);
        DTC_CK_DIV7:  src_tick[u] = !cfg[DTC_CFG_SLOW_BIT] &&
                                    prescale[6:0] == 7'h7F;
        DTC_CK_DIV5:  src_tick[u] = !cfg[DTC_CFG_SLOW_BIT] &&
                                    prescale[4:0] == 5'h1F;
        DTC_CK_DIV3:  src_tick[u] = !cfg[DTC_CFG_SLOW_BIT] &&
                                    prescale[2:0] == 3'h7;
        DTC_CK_LOW:   src_tick[u] = lf_edge;
        DTC_CK_DIV1:  src_tick[u] = !cfg[DTC_CFG_SLOW_BIT] &&
                                    prescale[0];
        // High clock survives slow operation only for warm-up counting
        DTC_CK_HIGH:  src_tick[u] = !cfg[DTC_CFG_SLOW_BIT] ||
                                    ctrl[1][DTC_MODE_MSB:DTC_MODE_LSB]
                                      == DTC_M_WARMUP;
        DTC_CK_PIN:   src_tick[u] = pin_edge;
        default:      src_tick[u] = 1'b0;
      endcase
    end
  end

  // Cascade follows the upper mode's top bit; taken from the register,
  // not the registered output, so run and cascade switch in one cycle
  assign cascade_sel   = ctrl[1][DTC_MODE_MSB];
  assign lower_cfg_run = cascade_sel ? ctrl[1][DTC_RUN_BIT]
                                     : ctrl[0][DTC_RUN_BIT];

  // Registered control outputs to the counting datapath
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cascade         <= 1'b0;
      lower_tick      <= 1'b0;
      upper_tick      <= 1'b0;
      lower_run       <= 1'b0;
      upper_run       <= 1'b0;
      lower_ff_preset <= 1'b0;
      upper_ff_preset <= 1'b0;
      lower_mode      <= 3'h0;
      upper_mode      <= 3'h0;
    end else begin
      cascade    <= cascade_sel;
      lower_mode <= ctrl[0][DTC_MODE_MSB:DTC_MODE_LSB];
      upper_mode <= ctrl[1][DTC_MODE_MSB:DTC_MODE_LSB];
      lower_run  <= lower_cfg_run;
      lower_tick <= lower_cfg_run && src_tick[0];
      // Reserved upper mode never runs, so nothing counts or fires
      upper_run  <= ctrl[1][DTC_RUN_BIT] &&
                    ctrl[1][DTC_MODE_MSB:DTC_MODE_LSB] != DTC_M_RSVD;
      upper_tick <= ctrl[1][DTC_RUN_BIT] &&
                    ctrl[1][DTC_MODE_MSB:DTC_MODE_LSB] != DTC_M_RSVD &&
                    (ctrl[1][DTC_MODE_MSB] ? lower_overflow
                                           : src_tick[1]);
      lower_ff_preset <= cascade_sel ? ctrl[1][DTC_FF_BIT]
                                     : ctrl[0][DTC_FF_BIT];
      upper_ff_preset <= ctrl[1][DTC_FF_BIT];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr)
      DTC_LOWER_CTRL_ADDR: next_rdata = ctrl[0];
      DTC_UPPER_CTRL_ADDR: next_rdata = ctrl[1];
      DTC_LOWER_PER_ADDR:  next_rdata = period[0];
      DTC_UPPER_PER_ADDR:  next_rdata = period[1];
      DTC_LOWER_WID_ADDR:  next_rdata = width[0];
      DTC_UPPER_WID_ADDR:  next_rdata = width[1];
      DTC_STATUS_ADDR:     next_rdata = {5'h00, cascade, upper_run, lower_run};
      DTC_CFG_ADDR:        next_rdata = {6'h00, cfg};
      default:             next_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst)     rdata <= 8'h00;
    else if (rd) rdata <= next_rdata;
    else         rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  run_clear_a: assert property (@(posedge clk) disable iff (rst)
    wr && addr == DTC_UPPER_CTRL_ADDR && !wdata[DTC_RUN_BIT]
    |=> ##1 !upper_run) else $error("upper run not cleared");
  frozen_a: assert property (@(posedge clk) disable iff (rst)
    ctrl[0][DTC_RUN_BIT] && $past(ctrl[0][DTC_RUN_BIT])
    |-> $stable(ctrl[0][DTC_MODE_MSB:DTC_MODE_LSB]))
    else $error("lower mode changed while running");
  reserved_idle_a: assert property (@(posedge clk) disable iff (rst)
    ctrl[1][DTC_MODE_MSB:DTC_MODE_LSB] == DTC_M_RSVD
    |=> !upper_tick && !upper_run) else $error("reserved upper active");
  cascade_clk_a: assert property (@(posedge clk) disable iff (rst)
    ctrl[1][DTC_MODE_MSB] && ctrl[1][DTC_RUN_BIT] && lower_overflow
    |=> upper_tick) else $error("overflow not passed up");
  slow_taps_a: assert property (@(posedge clk) disable iff (rst)
    cfg[DTC_CFG_SLOW_BIT] && ctrl[0][DTC_CK_MSB:DTC_CK_LSB] == DTC_CK_DIV3
    |=> !lower_tick) else $error("fast tap in slow operation");
  cascade_run_a: assert property (@(posedge clk) disable iff (rst)
    cascade |-> lower_run == $past(ctrl[1][DTC_RUN_BIT]))
    else $error("cascade run not from upper");
  reset_val_a: assert property (@(posedge clk)
    $fell(rst) |-> ctrl[0] == 8'h00 && ctrl[1] == 8'h00)
    else $error("control not zero after reset");
  read_back_a: assert property (@(posedge clk) disable iff (rst)
    rd && addr == DTC_LOWER_PER_ADDR && !wr |=> rdata == $past(period[0]))
    else $error("period read back wrong");

endmodule : dtc_ctrl

// File: dtc_ctrl_test.sv
// Purpose: Self-checking bench for the dual timer control registers
// Assumes: Sources are made from a cycle counter, so tick counts are fixed
// Notes:   Clock code and cascade lower tick counts allow one tick of slack for window alignment
`timescale 1ns/1ps
module dtc_ctrl_test
  import dtc_pkg::*;
;
  typedef struct {logic [7:0] cfg, a, v; int n;} dtc_row_t;

  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic       clk, rst, wr, rd, lower_overflow;
  logic       low_freq_clock, lower_pin, upper_pin;
  logic [7:0] addr, wdata, rdata;
  logic       lower_tick, upper_tick, lower_run, upper_run;
  logic       lower_ff_preset, upper_ff_preset, cascade;
  logic [2:0] lower_mode, upper_mode;
  int         err_total, compares, cyc, c;
  // Clock code rows: config, control address, control value, ticks in 640
  dtc_row_t rows[13] = '{
    '{8'h00, 8'h1A, 8'h18, 5},   '{8'h00, 8'h1A, 8'h28, 20},
    '{8'h00, 8'h1A, 8'h38, 80},  '{8'h00, 8'h1A, 8'h58, 320},
    '{8'h00, 8'h1A, 8'h68, 640}, '{8'h00, 8'h1A, 8'h48, 40},
    '{8'h00, 8'h1A, 8'h78, 80},  '{8'h01, 8'h1A, 8'h08, 5},
    '{8'h00, 8'h1B, 8'h78, 20},  '{8'h02, 8'h1A, 8'h38, 0},
    '{8'h02, 8'h1A, 8'h48, 40},  '{8'h02, 8'h1A, 8'h08, 5},
    '{8'h02, 8'h1A, 8'h68, 0}};

  dtc_ctrl dtc_ctrl_inst (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .low_freq_clock(low_freq_clock), .lower_pin(lower_pin),
    .upper_pin(upper_pin), .lower_overflow(lower_overflow),
    .lower_tick(lower_tick), .upper_tick(upper_tick),
    .lower_run(lower_run), .upper_run(upper_run),
    .lower_ff_preset(lower_ff_preset), .upper_ff_preset(upper_ff_preset),
    .lower_mode(lower_mode), .upper_mode(upper_mode), .cascade(cascade));

  // --------------------------------------------------------------
  // Clock, sources and hang guard
  // --------------------------------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // Slow clock period 16, pins 8 and 32 cycles; counter also cuts hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    low_freq_clock <= cyc[3];
    lower_pin <= cyc[2];
    upper_pin <= cyc[4];
    if (cyc == 40000) begin
      err_total = err_total + 1;
      summarize();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task chk(input logic [9:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr_reg

  task rd_chk(input logic [7:0] a, exp);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk(rdata, exp, "read");
    // Read data must fall back to zero one cycle later
    @(negedge clk);
    chk(rdata, 8'h00, "read release");
  endtask : rd_chk

  // Outputs follow a register change by one cycle
  task step();
    @(posedge clk);
    @(negedge clk);
  endtask : step

  task count(input bit up, input int n, output int k);
    k = 0;
    repeat (n) begin
      @(negedge clk);
      k += ((up ? upper_tick : lower_tick) === 1'b1);
    end
  endtask : count

  task summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {rst, wr, rd, lower_overflow, addr, wdata} = {4'h8, 16'h0000};
    {low_freq_clock, lower_pin, upper_pin, cyc} = 0;
    {err_total, compares} = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    // Every clock code normal, codes 000, 011, 100 and 110 slow, with readback of the control
    foreach (rows[i]) begin
      wr_reg(DTC_CFG_ADDR, rows[i].cfg);
      wr_reg(rows[i].a, rows[i].v);
      rd_chk(rows[i].a, rows[i].v);
      repeat (8) @(posedge clk);
      count(rows[i].a[0], 640, c);
      if (rows[i].n == 0) chk(c, 0, "idle ticks");
      else chk(c > rows[i].n + 1 || c + 1 < rows[i].n, 0, "ticks");
      wr_reg(rows[i].a, rows[i].v & 8'hF7);
      step();
      chk(lower_run | upper_run, 0, "stop");
    end
    wr_reg(DTC_CFG_ADDR, 8'h00);
    // Mid-run reset clears registers and outputs at once
    wr_reg(DTC_LOWER_CTRL_ADDR, 8'h38);
    @(posedge clk);
    rst <= 1;
    @(negedge clk);
    chk({lower_run, lower_tick}, 0, "reset outputs");
    @(posedge clk);
    rst <= 0;
    rd_chk(DTC_LOWER_CTRL_ADDR, 8'h00);
    rd_chk(DTC_CFG_ADDR, 8'h00);
    // Data registers, unmapped place and read-only status
    for (int k = 0; k < 4; k++) begin
      wr_reg(DTC_LOWER_PER_ADDR + k[7:0], 8'hA5 ^ k[7:0]);
      rd_chk(DTC_LOWER_PER_ADDR + k[7:0], 8'hA5 ^ k[7:0]);
    end
    wr_reg(8'h30, 8'hFF);
    rd_chk(8'h30, 8'h00);
    wr_reg(DTC_STATUS_ADDR, 8'hFF);
    rd_chk(DTC_STATUS_ADDR, 8'h00);
    // Start accepts fields; a rewrite while running keeps them
    wr_reg(DTC_LOWER_CTRL_ADDR, 8'hB9);
    step();
    chk({lower_run, lower_ff_preset, lower_mode}, 5'h19, "start");
    wr_reg(DTC_LOWER_CTRL_ADDR, 8'hFA);
    rd_chk(DTC_LOWER_CTRL_ADDR, 8'hB9);
    wr_reg(DTC_LOWER_CTRL_ADDR, 8'hB1);
    // Every upper mode code reaches the mode and cascade outputs
    for (int m = 0; m < 8; m++) begin
      wr_reg(DTC_UPPER_CTRL_ADDR, m[7:0]);
      step();
      chk({cascade, upper_mode}, {m[2], m[2:0]}, "mode");
    end
    // Cascade: lower clock select, upper start and preset
    wr_reg(DTC_LOWER_CTRL_ADDR, 8'h33);
    wr_reg(DTC_UPPER_CTRL_ADDR, 8'h8C);
    step();
    chk({cascade, lower_run, upper_run, lower_ff_preset}, 4'hF, "casc");
    chk(upper_ff_preset, 1, "upper preset");
    rd_chk(DTC_STATUS_ADDR, 8'h07);
    count(0, 64, c);
    chk(c > 9 || c < 7, 0, "cascade lower ticks");
    count(1, 32, c);
    chk(c, 0, "upper ticks without overflow");
    @(posedge clk);
    lower_overflow <= 1;
    @(posedge clk);
    lower_overflow <= 0;
    count(1, 4, c);
    chk(c, 1, "upper tick on overflow");
    wr_reg(DTC_UPPER_CTRL_ADDR, 8'h84);
    // Reserved upper mode stays idle even with start set
    wr_reg(DTC_UPPER_CTRL_ADDR, 8'h6B);
    step();
    count(1, 64, c);
    chk({upper_run, c[8:0]}, 0, "reserved idle");
    // Slow operation keeps the high clock only for warm-up counting
    wr_reg(DTC_UPPER_CTRL_ADDR, 8'h63);
    wr_reg(DTC_CFG_ADDR, 8'h02);
    wr_reg(DTC_LOWER_CTRL_ADDR, 8'h63);
    wr_reg(DTC_UPPER_CTRL_ADDR, 8'h0D);
    step();
    count(0, 64, c);
    chk(c, 64, "warm-up ticks");
    summarize();
  end
endmodule : dtc_ctrl_test

// File: dtc_pkg.sv
// Purpose: Constants shared by the dual timer control-register block
// Assumes: 8-bit register bus, byte addresses as printed
// Notes:   Field positions, codes and reset values live here only
package dtc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DTC_LOWER_CTRL_ADDR  = 8'h1A;
  localparam logic [7:0] DTC_UPPER_CTRL_ADDR  = 8'h1B;
  localparam logic [7:0] DTC_LOWER_PER_ADDR   = 8'h1C;
  localparam logic [7:0] DTC_UPPER_PER_ADDR   = 8'h1D;
  localparam logic [7:0] DTC_LOWER_WID_ADDR   = 8'h1E;
  localparam logic [7:0] DTC_UPPER_WID_ADDR   = 8'h1F;
  localparam logic [7:0] DTC_STATUS_ADDR      = 8'h20;
  localparam logic [7:0] DTC_CFG_ADDR         = 8'h21;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int DTC_FF_BIT    = 7;
  localparam int DTC_CK_MSB    = 6;
  localparam int DTC_CK_LSB    = 4;
  localparam int DTC_RUN_BIT   = 3;
  localparam int DTC_MODE_MSB  = 2;
  localparam int DTC_MODE_LSB  = 0;
  localparam logic [7:0] DTC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DTC_DATA_RESET = 8'h00;

  // Configuration register: bit 0 divider source, bit 1 slow operation
  localparam int DTC_CFG_DIV_BIT  = 0;
  localparam int DTC_CFG_SLOW_BIT = 1;

  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] DTC_CK_DIV11 = 3'h0;
  localparam logic [2:0] DTC_CK_DIV7  = 3'h1;
  localparam logic [2:0] DTC_CK_DIV5  = 3'h2;
  localparam logic [2:0] DTC_CK_DIV3  = 3'h3;
  localparam logic [2:0] DTC_CK_LOW   = 3'h4;
  localparam logic [2:0] DTC_CK_DIV1  = 3'h5;
  localparam logic [2:0] DTC_CK_HIGH  = 3'h6;
  localparam logic [2:0] DTC_CK_PIN   = 3'h7;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DTC_M_TIMER8  = 3'h0,
    DTC_M_DIVOUT8 = 3'h1,
    DTC_M_PWM8    = 3'h2,
    DTC_M_RSVD    = 3'h3,
    DTC_M_TIMER16 = 3'h4,
    DTC_M_WARMUP  = 3'h5,
    DTC_M_PWM16   = 3'h6,
    DTC_M_PULSE16 = 3'h7
  } dtc_mode_t;

  localparam int DTC_PRESCALE_W = 11;

endpackage : dtc_pkg
